// *** hw/cnt_irq_params.svh ***
// Constants for the counter and daisy-chain interrupt block.
// Included by count_channel and counter_interrupt_daisy_chain; definitions only.
`ifndef CNT_IRQ_PARAMS_SVH
`define CNT_IRQ_PARAMS_SVH
`define CH_COUNT 4
`define RETURN_FROM_INTERRUPT_OPCODE_FIRST_BYTE 8'hED
`define RETURN_FROM_INTERRUPT_OPCODE_SECOND_BYTE 8'h4D
`define CNT_RESET_VALUE 8'h00
`define VEC_RESET_VALUE 5'h00
`endif

// *** hw/cnt_irq_pkg.sv ***
// Types shared by the counter and daisy-chain interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package cnt_irq_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] ch_mask_t;
   typedef enum logic [1:0] {
      RETURN_FROM_INTERRUPT_OPCODE_IDLE = 2'b00,
      RETURN_FROM_INTERRUPT_OPCODE_SAW_ED = 2'b01
   } return_from_interrupt_opcode_state_t;
endpackage

// *** hw/count_channel.sv ***
// One counter-mode down-counter channel with trigger edge sync.
// Assumes a clocked trigger sampled through a two-stage synchroniser.
`timescale 1ns/1ps
`include "cnt_irq_params.svh"
module count_channel
   import cnt_irq_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic run_in,
   input wire logic trig_pol_in,
   input wire logic load_in,
   input wire cnt_irq_pkg::byte_t tc_in,
   input wire logic external_count_trigger_in,
   output logic zero_count_pulse_out
);
   logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, zc_q, zc_d;
   byte_t cnt_q, cnt_d;
   logic edge_w;

   // Synchroniser chain; first stage feeds only the second
   always_comb begin
      s1_d = external_count_trigger_in ^ ~trig_pol_in;
      s2_d = s1_q;
      s3_d = s2_q;
   end
   assign edge_w = s2_q & ~s3_q;

   // Late triggers miss s1 setup and land one cycle later
   // late edge delayed
   always_comb begin
      cnt_d = cnt_q;
      zc_d = 1'b0;
      if (load_in) begin
         cnt_d = tc_in;
      end else if (run_in && edge_w) begin
         cnt_d = cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            cnt_d = tc_in;
            zc_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         cnt_q <= `CNT_RESET_VALUE;
         zc_q <= 1'b0;
      end else if (clk_en_in) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         cnt_q <= cnt_d;
         zc_q <= zc_d;
      end
   end
   assign zero_count_pulse_out = zc_q;

   zc_one_cycle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      zc_q && clk_en_in |=> !zc_q) else $error("zero pulse longer than one cycle");
endmodule

// *** hw/counter_interrupt_daisy_chain.sv ***
// Counter channels plus vectored daisy-chain interrupt logic.
// Assumes a processor bus sampled synchronously to clk_sys_in.
`timescale 1ns/1ps
`include "cnt_irq_params.svh"
module counter_interrupt_daisy_chain
   import cnt_irq_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire cnt_irq_pkg::ch_mask_t run_in,
   input wire cnt_irq_pkg::ch_mask_t trig_pol_in,
   input wire cnt_irq_pkg::ch_mask_t load_in,
   input wire cnt_irq_pkg::byte_t tc_in,
   input wire cnt_irq_pkg::ch_mask_t irq_enable_in,
   input wire logic [4:0] vector_base_in,
   input wire cnt_irq_pkg::ch_mask_t external_count_trigger_in,
   input wire logic opcode_fetch_cycle_n_in,
   input wire logic io_request_n_in,
   input wire logic rd_n_in,
   input wire cnt_irq_pkg::byte_t data_in,
   input wire logic priority_chain_in,
   output cnt_irq_pkg::ch_mask_t zero_count_pulse_out,
   output logic priority_chain_out,
   output logic int_n_out,
   output logic int_oe_out,
   output cnt_irq_pkg::byte_t data_out,
   output logic data_oe_out
);
   ch_mask_t zc_w, pend_q, pend_d, serv_q, serv_d, ien_q, ien_d;
   return_from_interrupt_opcode_state_t return_from_interrupt_opcode_q, return_from_interrupt_opcode_d;
   byte_t vec_q, vec_d;
   logic drv_q, drv_d, io_request_q, io_request_d;
   logic ack_w, fetch_w, ack_start_w, blocked_w, busy_w, op_rd_w;
   logic op_seen_q, op_seen_d;
   ch_mask_t late_q, late_d;
   logic [1:0] win_w;

   // Lowest channel number wins; used for vector and in-service marking
   function automatic logic [1:0] top_ch(input ch_mask_t m);
      top_ch = 2'h0;
      for (int i = `CH_COUNT - 1; i >= 0; i--) begin
         if (m[i]) begin
            top_ch = 2'(i);
         end
      end
   endfunction

   // Channels of the given rank or higher; any of them in service holds a request off
   function automatic ch_mask_t at_or_above(input logic [1:0] c);
      at_or_above = 4'h0;
      for (int i = 0; i < `CH_COUNT; i++) begin
         if (i <= int'(c)) begin
            at_or_above[i] = 1'b1;
         end
      end
   endfunction

   // Four identical counter channels
   genvar g;
   generate
      for (g = 0; g < `CH_COUNT; g++) begin : g_ch
         count_channel u_ch (
            .clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in),
            .clk_en_in(clk_en_in),
            .run_in(run_in[g]),
            .trig_pol_in(trig_pol_in[g]),
            .load_in(load_in[g]),
            .tc_in(tc_in),
            .external_count_trigger_in(external_count_trigger_in[g]),
            .zero_count_pulse_out(zc_w[g])
         );
      end
   endgenerate
   assign zero_count_pulse_out = zc_w;

   // Bus decode; acknowledge only with read high
   assign fetch_w = ~opcode_fetch_cycle_n_in;
   assign ack_w = fetch_w & ~io_request_n_in & rd_n_in;
   assign ack_start_w = ack_w & ~io_request_q;
   // Opcode read; the processor holds it for several clocks, so act on its first one
   assign op_rd_w = fetch_w & io_request_n_in & ~rd_n_in;
   // only same or higher rank in service holds off
   assign blocked_w = |(serv_q & at_or_above(win_w));
   // Any channel in service closes the chain behind this device
   assign busy_w = |serv_q;
   assign win_w = top_ch(pend_q);

   // Request, service and vector logic
   always_comb begin
      pend_d = pend_q;
      serv_d = serv_q;
      ien_d = irq_enable_in;
      return_from_interrupt_opcode_d = return_from_interrupt_opcode_q;
      vec_d = vec_q;
      drv_d = drv_q;
      io_request_d = ~io_request_n_in;
      op_seen_d = op_rd_w;
      late_d = late_q;
      // set on enabled zero count
      // A zero count during a fetch is parked rather than lost, posted once fetch ends
      if (!fetch_w) begin
         pend_d = pend_q | late_q | (zc_w & ien_q);
         late_d = 4'h0;
      end else begin
         late_d = late_q | (zc_w & ien_q);
      end
      pend_d = pend_d & ien_q;
      late_d = late_d & ien_q;
      // vector at io fall, chain in high
      if (ack_start_w && priority_chain_in && |pend_q && !blocked_w) begin
         vec_d = {vector_base_in, win_w, 1'b0};
         drv_d = 1'b1;
         pend_d[win_w] = 1'b0;
         serv_d[win_w] = 1'b1;
      end else if (!ack_w) begin
         drv_d = 1'b0;
      end
      // return opcode tracked on fetch reads
      if (op_rd_w && !op_seen_q) begin
         case (return_from_interrupt_opcode_q)
            RETURN_FROM_INTERRUPT_OPCODE_IDLE: begin
               if (data_in == `RETURN_FROM_INTERRUPT_OPCODE_FIRST_BYTE) begin
                  return_from_interrupt_opcode_d = RETURN_FROM_INTERRUPT_OPCODE_SAW_ED;
               end
            end
            RETURN_FROM_INTERRUPT_OPCODE_SAW_ED: begin
               // only if chain in high here
               if (data_in == `RETURN_FROM_INTERRUPT_OPCODE_SECOND_BYTE && priority_chain_in) begin
                  serv_d[top_ch(serv_q)] = 1'b0;
               end
               return_from_interrupt_opcode_d = RETURN_FROM_INTERRUPT_OPCODE_IDLE;
            end
            default: begin
               return_from_interrupt_opcode_d = RETURN_FROM_INTERRUPT_OPCODE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_q <= 4'h0;
         serv_q <= 4'h0;
         ien_q <= 4'h0;
         return_from_interrupt_opcode_q <= RETURN_FROM_INTERRUPT_OPCODE_IDLE;
         vec_q <= 8'h00;
         drv_q <= 1'b0;
         io_request_q <= 1'b0;
         op_seen_q <= 1'b0;
         late_q <= 4'h0;
      end else if (clk_en_in) begin
         pend_q <= pend_d;
         serv_q <= serv_d;
         ien_q <= ien_d;
         return_from_interrupt_opcode_q <= return_from_interrupt_opcode_d;
         vec_q <= vec_d;
         drv_q <= drv_d;
         io_request_q <= io_request_d;
         op_seen_q <= op_seen_d;
         late_q <= late_d;
      end
   end

   assign priority_chain_out = priority_chain_in & ~busy_w;
   // open-drain request, pulled low while pending and not held off by same or higher rank in service
   assign int_oe_out = |pend_q & ~blocked_w;
   assign int_n_out = 1'b0;
   assign data_out = vec_q;
   assign data_oe_out = drv_q;

   chain_block_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      busy_w |-> !priority_chain_out) else $error("chain out high while serving");
   vec_low_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      data_oe_out |-> data_out[0] == 1'b0) else $error("vector bit zero set");
   vec_drive_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      $rose(data_oe_out) |-> $past(priority_chain_in) && $past(ack_w))
      else $error("vector without chain in");
   freeze_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      fetch_w && clk_en_in && !ack_start_w |=> (pend_q & ~$past(pend_q)) == 4'h0)
      else $error("request set during fetch");
   zero_req_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      clk_en_in && !fetch_w && |(zc_w & ien_q) |=> |pend_q || |serv_q)
      else $error("zero count lost");
   int_line_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      |pend_q && !blocked_w |-> int_oe_out) else $error("interrupt not asserted");
   vec_chan_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      $rose(data_oe_out) |-> data_out[2:1] == $past(win_w)
         && ($past(pend_q) & ~(4'hF << data_out[2:1])) == 4'h0)
      else $error("wrong channel");
   nest_hold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      $rose(data_oe_out) |-> ($past(serv_q) & ~(4'hE << data_out[2:1])) == 4'h0)
      else $error("vector under equal or higher service");
   park_req_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      clk_en_in && fetch_w && |(zc_w & ien_q) |=> |late_q)
      else $error("zero count dropped in fetch");
   release_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      $fell(|serv_q) |-> $past(return_from_interrupt_opcode_q) == RETURN_FROM_INTERRUPT_OPCODE_SAW_ED) else $error("release without return");
   ack_c: cover property (@(posedge clk_sys_in) $rose(data_oe_out));
   return_from_interrupt_opcode_c: cover property (@(posedge clk_sys_in) $fell(|serv_q));
   zc_c: cover property (@(posedge clk_sys_in) |zc_w);
   nest_c: cover property (@(posedge clk_sys_in) $rose(data_oe_out) && $past(busy_w));
endmodule

// *** verif/cpu_bus_model.sv ***
// Processor bus model: acknowledge and opcode fetch cycles.
// Assumes the bench calls its tasks; drives on falling edges.
`timescale 1ns/1ps
module cpu_bus_model
   import cnt_irq_pkg::*;
(
   input wire logic clk_sys_in,
   input wire cnt_irq_pkg::byte_t vec_in,
   input wire logic vec_oe_in,
   output logic fetch_n_out,
   output logic io_n_out,
   output logic rd_n_out,
   output cnt_irq_pkg::byte_t bus_out
);
   initial begin
      {fetch_n_out, io_n_out, rd_n_out} = 3'h7;
      bus_out = 8'h00;
   end
   task automatic ack(output byte_t vec, output logic seen);
      int i;
      vec = 8'h00;
      seen = 1'b0;
      @(negedge clk_sys_in) fetch_n_out = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      io_n_out = 1'b0;
      for (i = 0; i < 8 && !seen; i++) begin
         @(negedge clk_sys_in);
         if (vec_oe_in === 1'b1) begin
            vec = vec_in;
            seen = 1'b1;
         end
      end
      @(negedge clk_sys_in);
      {fetch_n_out, io_n_out} = 2'h3;
      bus_out = ~bus_out; // Inverts the released bus; after a fetch this brings back the last fetched byte
   endtask
   task automatic fetch(input byte_t b);
      @(negedge clk_sys_in);
      {fetch_n_out, rd_n_out} = 2'h0;
      bus_out = b;
      repeat (2) @(negedge clk_sys_in);
      {fetch_n_out, rd_n_out} = 2'h3;
      bus_out = ~b;
   endtask
endmodule

// *** verif/test_counter_interrupt_daisy_chain.sv ***
// Bench for counter channels and daisy-chain interrupts.
// Assumes cpu_bus_model plays the processor side.
`timescale 1ns/1ps
module test_counter_interrupt_daisy_chain;
   import cnt_irq_pkg::*;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic chain_in = 1'b0;
   logic chain_out, int_n, int_oe, data_oe, fetch_n, io_n, rd_n, seen;
   logic clk_en = 1'b1;
   ch_mask_t run = 4'h0, load = 4'h0, irq_en = 4'h0, trig = 4'h0, zc;
   ch_mask_t trig_pol = 4'hF;
   byte_t data_bus, vec, dout;
   int failures = 0;
   int num_checks = 0;
   localparam logic [4:0] BASE = 5'h15;
   counter_interrupt_daisy_chain DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en), .run_in(run), .trig_pol_in(trig_pol), .load_in(load), .tc_in(8'h01),
      .irq_enable_in(irq_en), .vector_base_in(BASE), .external_count_trigger_in(trig),
      .opcode_fetch_cycle_n_in(fetch_n), .io_request_n_in(io_n), .rd_n_in(rd_n),
      .data_in(data_bus), .priority_chain_in(chain_in), .zero_count_pulse_out(zc),
      .priority_chain_out(chain_out), .int_n_out(int_n), .int_oe_out(int_oe),
      .data_out(dout), .data_oe_out(data_oe));
   cpu_bus_model cpu (.clk_sys_in(clk_sys_in), .vec_in(dout), .vec_oe_in(data_oe),
      .fetch_n_out(fetch_n), .io_n_out(io_n), .rd_n_out(rd_n), .bus_out(data_bus));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Trigger pulses stay three clocks at the active level, seven idle
   task automatic fire(input ch_mask_t m, input ch_mask_t exp);
      ch_mask_t got;
      got = 4'h0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_sys_in);
         trig = ((i < 3) ? m : 4'h0) ^ ~trig_pol;
         got |= zc;
      end
      check(got, exp);
   endtask
   task automatic test_reset;
      check({zc, int_oe, data_oe, chain_out}, 8'h00);
      chain_in = 1'b1;
      #1 check(chain_out, 1'b1);
      repeat (2) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      $display("reset test done");
   endtask
   task automatic test_count;
      load = 4'hF;
      repeat (2) @(negedge clk_sys_in);
      load = 4'h0;
      run = 4'hF;
      irq_en = 4'b0101;
      fire(4'hF, 4'hF);
      check({int_n, int_oe}, 8'h01);
      // A low clock enable hides a whole trigger pulse
      clk_en = 1'b0;
      fire(4'b0010, 4'h0);
      clk_en = 1'b1;
      @(negedge clk_sys_in);
      // Falling-edge mode; idle level flips with polarity so no false edge
      trig_pol = 4'h0;
      trig = 4'hF;
      fire(4'b1000, 4'b1000);
      @(negedge clk_sys_in);
      trig_pol = 4'hF;
      trig = 4'h0;
      $display("count test done");
   endtask
   task automatic test_ack;
      cpu.ack(vec, seen);
      check(seen, 1'b1);
      check(vec, {BASE, 2'd0, 1'b0});
      check(chain_out, 1'b0);
      check(int_oe, 1'b0);
      $display("ack test done");
   endtask
   task automatic test_return;
      cpu.fetch(8'hED);
      cpu.fetch(8'h4D);
      @(negedge clk_sys_in);
      check({chain_out, int_oe}, 2'b11);
      chain_in = 1'b0;
      cpu.ack(vec, seen);
      check(seen, 1'b0);
      chain_in = 1'b1;
      cpu.ack(vec, seen);
      check(vec, {BASE, 2'd2, 1'b0});
      $display("return test done");
   endtask
   // Channel 2 in service; channel 0 nests above it
   task automatic test_nest;
      fire(4'b0001, 4'b0001);
      check({chain_out, int_oe}, 8'h01);
      cpu.ack(vec, seen);
      check(seen, 1'b1);
      check(vec, {BASE, 2'd0, 1'b0});
      cpu.fetch(8'hED);
      cpu.fetch(8'h4D);
      @(negedge clk_sys_in);
      check({chain_out, int_oe}, 8'h00);
      cpu.fetch(8'hED);
      cpu.fetch(8'h4D);
      @(negedge clk_sys_in);
      check({chain_out, int_oe}, 8'h02);
      $display("nest test done");
   endtask
   initial begin
      repeat (3) @(negedge clk_sys_in);
      test_reset;
      test_count;
      test_ack;
      test_return;
      test_nest;
      test_done;
   end
   // Whole run needs about 390 ns; allow far more
   initial begin
      #20000;
      failures++;
      test_done;
   end
endmodule
